// ===== inc/ebps_pkg.sv
// Constants for the external bus pin select block.
package ebps_pkg;
  localparam logic [15:0] EBPS_REG_ADDR   = 16'h1c00;
  localparam int          EBPS_DW         = 16;
  localparam int          EBPS_PP_LSB     = 12;
  localparam int          EBPS_PP_W       = 3;
  localparam int          EBPS_SG1_LSB    = 10;
  localparam int          EBPS_SG0_LSB    = 8;
  localparam int          EBPS_SG_W       = 2;
  localparam int          EBPS_ADDR_LSB   = 0;
  localparam int          EBPS_NADDR      = 6;
  localparam int          EBPS_PP_PINS    = 21;
  localparam int          EBPS_SG_PINS    = 6;
  localparam logic [15:0] EBPS_RST_VAL    = 16'h0000;
  localparam logic [15:0] EBPS_WMASK      = 16'h7f3f;
  localparam int          EBPS_NSRC       = 8;
endpackage : ebps_pkg

// ===== core/ebps_mux.sv
// Generic group source selector used for the shared pin groups; one select picks the source for all pins together.
`timescale 1ns/1ps
module ebps_mux #(
  parameter int PINS = 21,
  parameter int SELW = 3
) (
  input  wire logic [SELW-1:0]            sel,
  input  wire logic [(1<<SELW)*PINS-1:0]  src,
  output logic      [PINS-1:0]            pins
);
  assign pins = src[sel*PINS +: PINS];
endmodule : ebps_mux

// ===== core/ebps_top.sv
// Pin routing register and muxes for the shared parallel, serial and address pins.
`timescale 1ns/1ps
module ebps_top
  import ebps_pkg::*;
#(
  parameter int PPW = EBPS_PP_PINS,
  parameter int SGW = EBPS_SG_PINS
) (
  input  wire logic                      MCLK,
  input  wire logic                      RSTN,
  input  wire logic                      CE,
  input  wire logic [15:0]               PADDR,
  input  wire logic                      PWR,
  input  wire logic                      PRD,
  input  wire logic [EBPS_DW-1:0]        PWDATA,
  output logic      [EBPS_DW-1:0]        PRDATA,
  output logic                           PSEL_HIT,
  input  wire logic [EBPS_NSRC*PPW-1:0]  PP_SRC,
  output logic      [PPW-1:0]            PP_PINS,
  input  wire logic [4*SGW-1:0]          SG0_SRC,
  input  wire logic [4*SGW-1:0]          SG1_SRC,
  output logic      [SGW-1:0]            SG0_PINS,
  output logic      [SGW-1:0]            SG1_PINS,
  input  wire logic [EBPS_NADDR-1:0]     EXT_MEM_ADDR_IN,
  input  wire logic [EBPS_NADDR-1:0]     GPIO_OUT,
  input  wire logic [EBPS_NADDR-1:0]     GPIO_OE,
  output logic      [EBPS_NADDR-1:0]     EXT_MEM_ADDR_PINS_O,
  output logic      [EBPS_NADDR-1:0]     EXT_MEM_ADDR_PINS_OE,
  input  wire logic                      EXT_MEM_ADDR_OE,
  output logic      [EBPS_NADDR-1:0]     ADDR_GPIO_SELECT
);
  logic [EBPS_DW-1:0]        bus_pin_select_reg_q;
  logic [EBPS_DW-1:0]        bus_pin_select_reg_d;
  logic                      hit;
  logic                      wr_en;
  logic [EBPS_PP_W-1:0]      parallel_port_route_field;
  logic [EBPS_SG_W-1:0]      serial_group1_route_field;
  logic [EBPS_SG_W-1:0]      serial_group0_route_field;
  logic                      rd_en;
  logic [EBPS_NADDR-1:0]     wr_addr_bits;

  // Decodes the one port address that the register answers at.
  function automatic logic addr_match(input logic [15:0] addr);
    return addr == EBPS_REG_ADDR;
  endfunction : addr_match

  assign hit      = addr_match(PADDR);
  assign PSEL_HIT = hit & (PWR | PRD);
  assign wr_en    = CE & PWR & hit;
  assign rd_en    = CE & PRD & hit;
  // Reserved bits are masked so they never store and always read zero.
  assign bus_pin_select_reg_d = PWDATA & EBPS_WMASK;
  assign wr_addr_bits         = PWDATA[EBPS_ADDR_LSB +: EBPS_NADDR];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      bus_pin_select_reg_q <= EBPS_RST_VAL;
    end else if (wr_en) begin
      bus_pin_select_reg_q <= bus_pin_select_reg_d;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= EBPS_RST_VAL;
    end else if (rd_en) begin
      PRDATA <= bus_pin_select_reg_q;
    end
  end

  assign parallel_port_route_field = bus_pin_select_reg_q[EBPS_PP_LSB +: EBPS_PP_W];
  assign serial_group1_route_field = bus_pin_select_reg_q[EBPS_SG1_LSB +: EBPS_SG_W];
  assign serial_group0_route_field = bus_pin_select_reg_q[EBPS_SG0_LSB +: EBPS_SG_W];
  assign ADDR_GPIO_SELECT = bus_pin_select_reg_q[EBPS_ADDR_LSB +: EBPS_NADDR];

  ebps_mux #(.PINS(PPW), .SELW(EBPS_PP_W)) u_pp (
    .sel  (parallel_port_route_field),
    .src  (PP_SRC),
    .pins (PP_PINS)
  );
  ebps_mux #(.PINS(SGW), .SELW(EBPS_SG_W)) u_sg0 (
    .sel  (serial_group0_route_field),
    .src  (SG0_SRC),
    .pins (SG0_PINS)
  );
  ebps_mux #(.PINS(SGW), .SELW(EBPS_SG_W)) u_sg1 (
    .sel  (serial_group1_route_field),
    .src  (SG1_SRC),
    .pins (SG1_PINS)
  );

  genvar i;
  generate
    for (i = 0; i < EBPS_NADDR; i++) begin : g_addr
      assign EXT_MEM_ADDR_PINS_O[i]  = ADDR_GPIO_SELECT[i] ? GPIO_OUT[i] : EXT_MEM_ADDR_IN[i];
      assign EXT_MEM_ADDR_PINS_OE[i] = ADDR_GPIO_SELECT[i] ? GPIO_OE[i]  : EXT_MEM_ADDR_OE;
    end
  endgenerate

  a_write_next_cycle: assert property (@(posedge MCLK) disable iff (!RSTN)
    wr_en |=> bus_pin_select_reg_q == $past(bus_pin_select_reg_d))
    else $error("Register did not take the write on the next clock.");
  a_hold_no_write: assert property (@(posedge MCLK) disable iff (!RSTN)
    !wr_en |=> $stable(bus_pin_select_reg_q))
    else $error("Register changed without a write.");
  a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (bus_pin_select_reg_q & ~EBPS_WMASK) == '0)
    else $error("Reserved bits are not zero.");
  a_addr_gpio_pin: assert property (@(posedge MCLK) disable iff (!RSTN)
    ADDR_GPIO_SELECT[0] |-> EXT_MEM_ADDR_PINS_O[0] == GPIO_OUT[0])
    else $error("Address pin zero not in gpio mode.");
  a_addr_mem_pin: assert property (@(posedge MCLK) disable iff (!RSTN)
    !ADDR_GPIO_SELECT[5] |-> EXT_MEM_ADDR_PINS_OE[5] == EXT_MEM_ADDR_OE)
    else $error("Address pin five lost memory function.");
  a_pp_route: assert property (@(posedge MCLK) disable iff (!RSTN)
    wr_en && PWDATA[EBPS_PP_LSB +: EBPS_PP_W] == 3'h0 |=> PP_PINS == PP_SRC[PPW-1:0])
    else $error("Parallel route zero not applied.");
  a_sg0_route: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group0_route_field == 2'h1 |-> SG0_PINS == SG0_SRC[SGW +: SGW])
    else $error("Serial group route wrong.");
  a_mode_bits_rw: assert property (@(posedge MCLK) disable iff (!RSTN)
    wr_en |=> ADDR_GPIO_SELECT == $past(wr_addr_bits))
    else $error("Address mode bits not written.");

  // A write followed at once by a read must return the word just written.
  sequence s_write_then_read;
    wr_en ##1 rd_en;
  endsequence

  // A write strobe at any other port address.
  sequence s_foreign_write;
    CE && PWR && !addr_match(PADDR);
  endsequence

  // A cycle in which the clock enable holds every register still.
  sequence s_frozen_cycle;
    !CE;
  endsequence

  a_read_returns_reg: assert property (@(posedge MCLK) disable iff (!RSTN)
    rd_en |=> PRDATA == $past(bus_pin_select_reg_q))
    else $error("Read data does not match the register.");
  a_write_then_read: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_write_then_read |=> PRDATA == $past(bus_pin_select_reg_d, 2))
    else $error("Back to back read missed the word just written.");
  a_refuse_foreign: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_foreign_write |=> $stable(bus_pin_select_reg_q))
    else $error("Write at another address changed the register.");
  a_ce_freeze: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_frozen_cycle |=> $stable(bus_pin_select_reg_q) && $stable(PRDATA))
    else $error("State changed while the clock enable was low.");
  a_read_holds: assert property (@(posedge MCLK) disable iff (!RSTN)
    !rd_en |=> $stable(PRDATA))
    else $error("Read data changed without a read.");

  a_hit_addr: assert property (@(posedge MCLK) disable iff (!RSTN)
    PSEL_HIT |-> PADDR == EBPS_REG_ADDR)
    else $error("Select flag raised at another address.");
  a_hit_strobe: assert property (@(posedge MCLK) disable iff (!RSTN)
    !PWR && !PRD |-> !PSEL_HIT)
    else $error("Select flag raised without a strobe.");
  a_hit_read: assert property (@(posedge MCLK) disable iff (!RSTN)
    PRD && PADDR == EBPS_REG_ADDR |-> PSEL_HIT)
    else $error("Select flag missing on a read of the register.");
  a_read_reserved: assert property (@(posedge MCLK) disable iff (!RSTN)
    (PRDATA & ~EBPS_WMASK) == '0)
    else $error("Reserved bits read back as nonzero.");

  // Route checks cover the first and the last source of each pin group.
  a_pp_default: assert property (@(posedge MCLK) disable iff (!RSTN)
    parallel_port_route_field == '0 |-> PP_PINS == PP_SRC[PPW-1:0])
    else $error("Parallel default route wrong.");
  a_pp_route_top: assert property (@(posedge MCLK) disable iff (!RSTN)
    parallel_port_route_field == EBPS_PP_W'(EBPS_NSRC - 1)
      |-> PP_PINS == PP_SRC[(EBPS_NSRC-1)*PPW +: PPW])
    else $error("Parallel route of the last source not applied.");
  a_sg0_default: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group0_route_field == '0 |-> SG0_PINS == SG0_SRC[SGW-1:0])
    else $error("Serial group zero default route wrong.");
  a_sg0_route_top: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group0_route_field == 2'h3 |-> SG0_PINS == SG0_SRC[3*SGW +: SGW])
    else $error("Serial group zero last route wrong.");
  a_sg1_default: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group1_route_field == '0 |-> SG1_PINS == SG1_SRC[SGW-1:0])
    else $error("Serial group one default route wrong.");
  a_sg1_route: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group1_route_field == 2'h2 |-> SG1_PINS == SG1_SRC[2*SGW +: SGW])
    else $error("Serial group one route wrong.");
  a_sg1_route_top: assert property (@(posedge MCLK) disable iff (!RSTN)
    serial_group1_route_field == 2'h3 |-> SG1_PINS == SG1_SRC[3*SGW +: SGW])
    else $error("Serial group one last route wrong.");

  // Every address pin is checked in both of its modes.
  generate
    for (i = 0; i < EBPS_NADDR; i++) begin : g_addr_chk
      a_pin_gpio_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
        ADDR_GPIO_SELECT[i] |-> EXT_MEM_ADDR_PINS_O[i] == GPIO_OUT[i]
          && EXT_MEM_ADDR_PINS_OE[i] == GPIO_OE[i])
        else $error("Address pin in gpio mode does not follow the gpio side.");
      a_pin_mem_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
        !ADDR_GPIO_SELECT[i] |-> EXT_MEM_ADDR_PINS_O[i] == EXT_MEM_ADDR_IN[i]
          && EXT_MEM_ADDR_PINS_OE[i] == EXT_MEM_ADDR_OE)
        else $error("Address pin in memory mode lost its address function.");
    end
  endgenerate
endmodule : ebps_top

// ===== sim/ebps_far_model.sv
// Model of the peripheral sources and pin-side drivers around the pin select block.
`timescale 1ns/1ps
module ebps_far_model
  import ebps_pkg::*;
(
  output logic [EBPS_NSRC*21-1:0] PP_SRC,
  output logic [23:0]             SG0_SRC,
  output logic [23:0]             SG1_SRC,
  output logic [5:0]              EXT_MEM_ADDR_IN,
  output logic [5:0]              GPIO_OUT,
  output logic [5:0]              GPIO_OE,
  output logic                    EXT_MEM_ADDR_OE
);
  // Sources stay static, as if their clocks were gated and reset around each routing change.
  for (genvar k = 0; k < EBPS_NSRC; k++) begin : g_pp
    assign PP_SRC[k*21+:21] = 21'(k * 'h49249);
  end
  for (genvar k = 0; k < 4; k++) begin : g_sg
    assign SG0_SRC[k*6+:6] = 6'(k * 'h15);
    assign SG1_SRC[k*6+:6] = ~6'(k * 'h15);
  end
  assign EXT_MEM_ADDR_IN = 6'h15;
  assign GPIO_OUT        = 6'h2a;
  assign GPIO_OE         = 6'h0f;
  assign EXT_MEM_ADDR_OE = 1'b1;
endmodule : ebps_far_model

// ===== sim/tb_top.sv
// Self-checking bench for the pin select block.
`timescale 1ns/1ps
module tb_top;
  import ebps_pkg::*;
  logic mclk = 0, rstn = 0, ce = 1, pwr = 0, prd = 0, aoe, hit;
  logic [15:0] paddr = 16'h0000, pwdata = 16'h0000, prdata, d;
  logic [EBPS_NSRC*21-1:0] pp_src;
  logic [23:0] sg0_src, sg1_src;
  logic [20:0] pp_pins;
  logic [5:0] sg0_pins, sg1_pins, ain, gout, goe, apo, apoe, asel;
  int errors = 0, check_count = 0;
  initial forever #5 mclk = ~mclk;
  ebps_top dut (.MCLK(mclk), .RSTN(rstn), .CE(ce), .PADDR(paddr), .PWR(pwr), .PRD(prd),
    .PWDATA(pwdata), .PRDATA(prdata), .PSEL_HIT(hit), .PP_SRC(pp_src), .PP_PINS(pp_pins),
    .SG0_SRC(sg0_src), .SG1_SRC(sg1_src), .SG0_PINS(sg0_pins), .SG1_PINS(sg1_pins),
    .EXT_MEM_ADDR_IN(ain), .GPIO_OUT(gout), .GPIO_OE(goe), .EXT_MEM_ADDR_PINS_O(apo),
    .EXT_MEM_ADDR_PINS_OE(apoe), .EXT_MEM_ADDR_OE(aoe), .ADDR_GPIO_SELECT(asel));
  ebps_far_model far (.PP_SRC(pp_src), .SG0_SRC(sg0_src), .SG1_SRC(sg1_src),
    .EXT_MEM_ADDR_IN(ain), .GPIO_OUT(gout), .GPIO_OE(goe), .EXT_MEM_ADDR_OE(aoe));
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge mclk);
    paddr <= a;
    pwdata <= v;
    pwr <= 1'b1;
    @(posedge mclk);
    pwr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk);
    paddr <= a;
    prd <= 1'b1;
    #1;
    chk("hit", {20'h0, a === EBPS_REG_ADDR}, {20'h0, hit});
    @(posedge mclk);
    prd <= 1'b0;
    #1;
    chk("read", {5'h0, exp}, {5'h0, prdata});
  endtask : rd
  task automatic wr_rd(input logic [15:0] v, input logic [15:0] exp);
    @(posedge mclk);
    paddr <= EBPS_REG_ADDR;
    pwdata <= v;
    pwr <= 1'b1;
    @(posedge mclk);
    pwr <= 1'b0;
    prd <= 1'b1;
    @(posedge mclk);
    prd <= 1'b0;
    #1;
    chk("read back", {5'h0, exp}, {5'h0, prdata});
  endtask : wr_rd
  task automatic pins(input logic [15:0] v);
    chk("pp", 21'(v[14:12] * 21'h49249), pp_pins);
    chk("sg0", {15'h0, 6'(v[9:8] * 6'h15)}, {15'h0, sg0_pins});
    chk("sg1", {15'h0, ~6'(v[11:10] * 6'h15)}, {15'h0, sg1_pins});
    chk("sel", {15'h0, v[5:0]}, {15'h0, asel});
    chk("ao", {15'h0, (v[5:0] & 6'h2a) | (~v[5:0] & 6'h15)}, {15'h0, apo});
    chk("aoe", {15'h0, (v[5:0] & 6'h0f) | ~v[5:0]}, {15'h0, apoe});
  endtask : pins
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(16'h1c00, 16'h0000);
    pins(16'h0000);
    $display("test reset done");
    wr(16'h1c00, 16'hffff);
    pins(16'h7f3f);
    rd(16'h1c00, 16'h7f3f);
    $display("test all ones done");
    for (int v = 0; v < 8; v++) begin
      d = {1'b0, 3'(v), 2'(v), 2'(v + 1), 2'b00, 6'(1 << (v % 6))};
      wr(16'h1c00, d);
      pins(d);
      rd(16'h1c00, d);
    end
    $display("test field sweep done");
    wr(16'h1c01, 16'h0000);
    pins(d);
    wr(16'h1c00, 16'h0000);
    rd(16'h1c01, d);
    $display("test foreign address done");
    @(posedge mclk);
    ce <= 1'b0;
    wr(16'h1c00, 16'h7f3f);
    pins(16'h0000);
    rd(16'h1c00, d);
    @(posedge mclk);
    ce <= 1'b1;
    $display("test clock enable done");
    wr_rd(16'hffff, 16'h7f3f);
    pins(16'h7f3f);
    $display("test back to back done");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(16'h1c00, 16'h0000);
    pins(16'h0000);
    $display("test mid reset done");
    summarize();
  end
endmodule : tb_top
